//--- logic/tsl_consts.svh
`ifndef TSL_CONSTS_SVH
`define TSL_CONSTS_SVH

// Fixed pipeline ahead of the boxcar, chosen so output midpoint lands at base + L/2
`define TSL_REAL_BASE       41
`define TSL_CPLX_BASE       35
`define TSL_REAL_PRE        40
`define TSL_CPLX_PRE        34

// Boxcar length per unit of decimation (midpoint factor times two)
`define TSL_REAL_LEN_MUL    40
`define TSL_CPLX_LEN_MUL    20

// Legal log2 decimation ranges
`define TSL_REAL_SEL_MIN    3'h0
`define TSL_REAL_SEL_MAX    3'h5
`define TSL_CPLX_SEL_MIN    3'h1
`define TSL_CPLX_SEL_MAX    3'h6

// Word strobe timing after a sync strobe, in clocks, and the decimation from which the cap applies
`define TSL_WS_SETTLE       9
`define TSL_WS_FIRST_BASE   8
`define TSL_WS_FIRST_CAP    24
`define TSL_WS_CAP_DEC      16

// Reset values
`define TSL_CNT_RST         6'h00
`define TSL_PH_RST          7'h00

`endif

//--- logic/tsl_pkg.sv
package tsl_pkg;

    // Word strobe sequencer: free running, settling after sync, running
    typedef enum logic [1:0] {
        TSL_FREE,
        TSL_SETTLE,
        TSL_RUN
    } tsl_ws_state_t;

endpackage

//--- logic/tsl_tap_line.sv
`timescale 1ns/1ps

// Ring of past samples with two read taps at a given age; ages not yet filled read as zero
module tsl_tap_line #(
    parameter int DW = 12,
    parameter int AW = 11
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Write side
    input  wire logic                 clear,
    input  wire logic signed [DW-1:0] din,
    // Read taps, age 0 is the newest sample
    input  wire logic        [AW-1:0] age_a,
    input  wire logic        [AW-1:0] age_b,
    output logic signed      [DW-1:0] tap_a,
    output logic signed      [DW-1:0] tap_b
);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW:0]   fill;
    } tsl_tap_state_t;

    tsl_tap_state_t        st_r;
    tsl_tap_state_t        st_nxt;
    logic signed [DW-1:0]  mem [0:(1<<AW)-1];

    // Age is valid only once more than that many samples have been written since the last clear
    function automatic logic signed [DW-1:0] read_age(input logic [AW-1:0] age);
        logic [AW-1:0] addr;
        addr = st_r.wp - age - AW'(1);
        if ({1'b0, age} < st_r.fill) begin
            read_age = mem[addr];
        end else begin
            read_age = '0;
        end
    endfunction

    assign tap_a = read_age(age_a);
    assign tap_b = read_age(age_b);

    always_comb begin
        st_nxt    = st_r;
        st_nxt.wp = st_r.wp + AW'(1);
        if (clear) begin
            st_nxt.fill = '0;
        end else if (st_r.fill != {1'b1, {AW{1'b0}}}) begin
            st_nxt.fill = st_r.fill + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // No reset on the array: the fill count hides stale words instead
    always_ff @(posedge clk) begin
        mem[st_r.wp] <= din;
    end

endmodule // tsl_tap_line

//--- logic/tsl_top.sv
`timescale 1ns/1ps
`include "tsl_consts.svh"

// How it works
// R1: In real mode a step at the input reaches half height after 41+20D clocks and settles after 41+40D, D in 1..32.
// R2: In complex mode a step reaches half height after 35+10D clocks and settles after 35+20D, D in 2..64.
// R3: After a sync strobe the word strobe may be anything for 9 clocks, then stays low until its first high.
// R4: The first word strobe after sync comes 10, 12 or 16 clocks later for decimation 2, 4 or 8.
// R5: For decimation 16, 32 or 64 the first word strobe after sync comes 24 clocks later.
// R6: At the 24th clock after sync the word strobe is high for every decimation.
// R7: One chip's one-shot output drives every chip's sync strobe, so one pulse aligns all output frames.
// R8: A second chip's one-shot output drives every accumulator-sync input, restarting all phase accumulators together.
// R9: For complex input two synchronised chips take I and Q, and outside logic adds and subtracts their outputs.
// R10: All latencies count rising clock edges from the edge that samples the step or the sync strobe.
module tsl_top #(
    parameter int IW = 12,
    parameter int FW = 32,
    parameter int AW = 11
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Configuration
    input  wire logic                 complex_mode,
    input  wire logic        [2:0]    dec_sel,
    input  wire logic        [FW-1:0] freq_word,
    // Sample stream
    input  wire logic signed [IW-1:0] sample_in,
    output logic signed      [IW+AW:0] data_out,
    output logic                      output_word_strobe,
    // Synchronisation
    input  wire logic                 sync_strobe_in_n,
    input  wire logic                 accumulator_sync_in_n,
    input  wire logic                 one_shot_req,
    output logic                      one_shot_out_n,
    // Frequency accumulator
    output logic             [FW-1:0] phase_out
);

    localparam int SW = IW + AW + 1;

    typedef struct packed {
        tsl_pkg::tsl_ws_state_t ws_state;
        logic [5:0]             sync_cnt;
        logic [6:0]             ph;
        logic                   ws;
        logic signed [SW-1:0]   sum;
        logic signed [SW-1:0]   dout;
        logic                   os_n;
        logic [FW-1:0]          phase;
    } tsl_state_t;

    tsl_state_t           st_r;
    tsl_state_t           st_nxt;
    logic [2:0]           sel_eff;
    logic [6:0]           dec;
    logic [AW-1:0]        pre_age;
    logic [AW-1:0]        old_age;
    logic [5:0]           first_ws;
    logic                 sync_hit;
    logic signed [IW-1:0] tap_new;
    logic signed [IW-1:0] tap_old;

    // Illegal decimation codes are pulled into the legal range of the current mode
    function automatic logic [2:0] clamp_sel(input logic cplx, input logic [2:0] sel);
        logic [2:0] lo;
        logic [2:0] hi;
        lo = cplx ? `TSL_CPLX_SEL_MIN : `TSL_REAL_SEL_MIN;
        hi = cplx ? `TSL_CPLX_SEL_MAX : `TSL_REAL_SEL_MAX;
        if (sel < lo) begin
            clamp_sel = lo;
        end else if (sel > hi) begin
            clamp_sel = hi;
        end else begin
            clamp_sel = sel;
        end
    endfunction

    // Boxcar length in samples for a mode and decimation
    function automatic logic [AW-1:0] box_len(input logic cplx, input logic [6:0] d);
        if (cplx) begin
            box_len = AW'(d * `TSL_CPLX_LEN_MUL);
        end else begin
            box_len = AW'(d * `TSL_REAL_LEN_MUL);
        end
    endfunction

    // Fixed front delay ahead of the boxcar for a mode
    function automatic logic [AW-1:0] pre_len(input logic cplx);
        if (cplx) begin
            pre_len = AW'(`TSL_CPLX_PRE);
        end else begin
            pre_len = AW'(`TSL_REAL_PRE);
        end
    endfunction

    // First strobe is 8+D clocks after sync, capped at 24 so the long ratios share one slot
    function automatic logic [5:0] first_strobe_at(input logic [6:0] d);
        if (d >= 7'(`TSL_WS_CAP_DEC)) begin
            first_strobe_at = 6'(`TSL_WS_FIRST_CAP);                                  // see R5
        end else begin
            first_strobe_at = 6'(`TSL_WS_FIRST_BASE) + 6'(d);                         // see R4
        end
    endfunction

    // Last clock of a strobe period of d clocks
    function automatic logic period_end(input logic [6:0] p, input logic [6:0] d);
        period_end = (p == d - 7'h01);
    endfunction

    assign sel_eff  = clamp_sel(complex_mode, dec_sel);
    assign dec      = 7'h01 << sel_eff;
    // Pin is active low; one low clock is one sync
    assign sync_hit = !sync_strobe_in_n;

    // Fixed front delay plus a boxcar of length L: the output passes half height
    // after pre+1+L/2 edges and settles after pre+1+L edges
    assign pre_age = pre_len(complex_mode);                                          // see R1 see R2
    assign old_age = pre_age + box_len(complex_mode, dec);                          // see R1 see R2

    assign first_ws = first_strobe_at(dec);                                         // see R4 see R5

    // Sync clears the history as well, so an old frame cannot reach the new one
    tsl_tap_line #(
        .DW(IW),
        .AW(AW)
    ) u_tsl_tap_line (
        .clk   (clk),
        .rst_n (rst_n),
        .clear (sync_hit),
        .din   (sample_in),
        .age_a (pre_age),
        .age_b (old_age),
        .tap_a (tap_new),
        .tap_b (tap_old)
    );

    always_comb begin
        st_nxt = st_r;

        // Running boxcar sum and its output register
        // L times the largest sample still fits the sum width, so it never wraps
        st_nxt.sum  = st_r.sum + SW'(tap_new) - SW'(tap_old);                       // see R1 see R2 see R10
        st_nxt.dout = st_r.sum;

        // Sync restarts the filter history so stale words do not leak across frames
        if (sync_hit) begin
            st_nxt.sum = '0;
        end

        // Word strobe sequencer
        st_nxt.ws = 1'b0;
        unique case (st_r.ws_state)
            tsl_pkg::TSL_FREE,
            tsl_pkg::TSL_RUN: begin
                if (period_end(st_r.ph, dec)) begin
                    st_nxt.ws = 1'b1;
                    st_nxt.ph = 7'h00;
                end else begin
                    st_nxt.ph = st_r.ph + 7'h01;
                end
            end
            tsl_pkg::TSL_SETTLE: begin
                // Held low the whole wait, which also meets the settle window
                st_nxt.sync_cnt = st_r.sync_cnt + 6'h01;                              // see R10
                if (st_r.sync_cnt == first_ws) begin
                    st_nxt.ws       = 1'b1;                                           // see R4 see R5 see R6
                    st_nxt.ph       = 7'h00;
                    st_nxt.ws_state = tsl_pkg::TSL_RUN;
                end
                // Never raised inside the settle window, whatever the ratio
                if (st_r.sync_cnt < 6'(`TSL_WS_SETTLE)) begin
                    st_nxt.ws = 1'b0;                                                 // see R3
                end
            end
            default: begin
                // Unused state code: fall back to free running
                st_nxt.ws_state = tsl_pkg::TSL_FREE;
                st_nxt.ph       = `TSL_PH_RST;
            end
        endcase

        // Sync edge counts as clock 0; counter holds the clock number seen at each edge
        if (sync_hit) begin
            st_nxt.ws       = 1'b0;                                                   // see R3
            st_nxt.sync_cnt = 6'h01;
            st_nxt.ph       = `TSL_PH_RST;
            st_nxt.ws_state = tsl_pkg::TSL_SETTLE;
        end

        // One-shot pulse for the bank's sync or accumulator-sync net
        // Registered, so every chip in the bank sees the pulse on the same edge
        st_nxt.os_n = !one_shot_req;                                                  // see R7 see R8

        // Frequency accumulator, restarted in step across the bank
        // Wraps modulo 2^FW, which is one turn of the phase circle
        if (!accumulator_sync_in_n) begin
            st_nxt.phase = '0;                                                        // see R8
        end else begin
            st_nxt.phase = st_r.phase + freq_word;
        end
    end

    // Reset leaves the strobe free running from the first edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.ws_state <= tsl_pkg::TSL_FREE;
            st_r.sync_cnt <= `TSL_CNT_RST;
            st_r.ph       <= `TSL_PH_RST;
            st_r.os_n     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_out           = st_r.dout;
    assign output_word_strobe = st_r.ws;
    assign one_shot_out_n     = st_r.os_n;
    assign phase_out          = st_r.phase;

endmodule // tsl_top

//--- verification/tsl_sync_source.sv
`timescale 1ns/1ps
// Second tuner of the bank, seen only through its one-shot pin
module tsl_sync_source (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pulse request and pin
    input  wire logic fire,
    output logic      pulse_n
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_n <= 1'b1;
        end else begin
            pulse_n <= !fire;
        end
    end
endmodule // tsl_sync_source

//--- verification/tsl_top_properties.sv
`timescale 1ns/1ps
module tsl_top_properties #(
    parameter int IW = 12,
    parameter int FW = 32,
    parameter int AW = 11
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  complex_mode,
    input wire logic        [2:0]     dec_sel,
    input wire logic        [FW-1:0]  freq_word,
    input wire logic signed [IW-1:0]  sample_in,
    input wire logic signed [IW+AW:0] data_out,
    input wire logic                  output_word_strobe,
    input wire logic                  sync_strobe_in_n,
    input wire logic                  accumulator_sync_in_n,
    input wire logic                  one_shot_req,
    input wire logic                  one_shot_out_n,
    input wire logic        [FW-1:0]  phase_out
);
    logic       ws;
    logic [2:0] sel;
    assign ws = output_word_strobe;
    // Same clamping as the design applies to out-of-range selections
    assign sel = complex_mode ? ((dec_sel < 3'h1) ? 3'h1 : (dec_sel > 3'h6) ? 3'h6 : dec_sel)
                              : ((dec_sel > 3'h5) ? 3'h5 : dec_sel);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_sync;
        !sync_strobe_in_n;
    endsequence
    sequence s_low8;
        (!ws)[*8];
    endsequence
    a_ws_first_d2: assert property (s_sync ##0 sel == 3'h1 |-> ##9 (!ws)[*2] ##1 ws)
        else $error("first strobe wrong for decimation 2");
    a_ws_first_d4: assert property (s_sync ##0 sel == 3'h2 |-> ##9 (!ws)[*4] ##1 ws)
        else $error("first strobe wrong for decimation 4");
    a_ws_first_d8: assert property (s_sync ##0 sel == 3'h3 |-> ##9 s_low8 ##1 ws)
        else $error("first strobe wrong for decimation 8");
    a_ws_first_long: assert property (s_sync ##0 sel >= 3'h4 |-> ##9 s_low8 ##1 s_low8 ##1 ws)
        else $error("first strobe wrong for long decimation");
    a_ws_at_24: assert property (s_sync |-> ##25 ws)
        else $error("strobe low at clock 24");
    a_one_shot: assert property (1'b1 |=> one_shot_out_n != $past(one_shot_req))
        else $error("one-shot pulse wrong");
    a_acc_zero: assert property (!accumulator_sync_in_n |=> phase_out == '0)
        else $error("accumulator not restarted");
    a_acc_step: assert property (accumulator_sync_in_n |=> phase_out == $past(phase_out) + $past(freq_word))
        else $error("accumulator step wrong");
endmodule // tsl_top_properties

bind tsl_top tsl_top_properties #(.IW(IW), .FW(FW), .AW(AW)) u_tsl_top_properties (.clk(clk), .rst_n(rst_n),
    .complex_mode(complex_mode), .dec_sel(dec_sel), .freq_word(freq_word), .sample_in(sample_in),
    .data_out(data_out), .output_word_strobe(output_word_strobe), .sync_strobe_in_n(sync_strobe_in_n),
    .accumulator_sync_in_n(accumulator_sync_in_n), .one_shot_req(one_shot_req),
    .one_shot_out_n(one_shot_out_n), .phase_out(phase_out));

//--- verification/tsl_top_tb_top.sv
`timescale 1ns/1ps
module tsl_top_tb_top;
    logic               clk, rst_n, complex_mode, one_shot_req, fire, ws, os_n, as_n, ws_q;
    logic        [2:0]  dec_sel;
    logic        [31:0] freq_word, phase_out;
    logic signed [11:0] sample_in, sample_q;
    logic signed [23:0] data_out, data_q;
    logic signed [24:0] iq_sum, iq_dif;
    int                 n_errors, cmp_count;
    // One-shot tied back to the sync input, as in a bank
    tsl_top u_tsl_top (.clk(clk), .rst_n(rst_n), .complex_mode(complex_mode), .dec_sel(dec_sel),
        .freq_word(freq_word), .sample_in(sample_in), .data_out(data_out), .output_word_strobe(ws),
        .sync_strobe_in_n(os_n), .accumulator_sync_in_n(as_n), .one_shot_req(one_shot_req),
        .one_shot_out_n(os_n), .phase_out(phase_out));
    tsl_sync_source u_tsl_sync_source (.clk(clk), .rst_n(rst_n), .fire(fire), .pulse_n(as_n));
    // Quadrature chip of the pair, synchronised by the same nets
    tsl_top u_tsl_top_q (.clk(clk), .rst_n(rst_n), .complex_mode(complex_mode), .dec_sel(dec_sel),
        .freq_word(freq_word), .sample_in(sample_q), .data_out(data_q), .output_word_strobe(ws_q),
        .sync_strobe_in_n(os_n), .accumulator_sync_in_n(as_n), .one_shot_req(1'b0),
        .one_shot_out_n(), .phase_out());
    // Downstream combiner of the pair
    assign iq_sum = data_out + data_q;
    assign iq_dif = data_out - data_q;
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic sync_now();
        one_shot_req = 1'b1;
        tick(1);
        one_shot_req = 1'b0;
        check("one-shot pin", 32'h0, 32'(os_n));
    endtask
    task automatic test_accum();
        freq_word = 32'h0123_4567;
        tick(5);
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        tick(1);
        check("phase restart", 32'h0, phase_out);
        tick(1);
        check("phase step 1", 32'h0123_4567, phase_out);
        tick(1);
        check("phase step 2", 32'h0246_8ACE, phase_out);
    endtask
    task automatic test_sync(logic cm, logic [2:0] sel, int first);
        complex_mode = cm;
        dec_sel = sel;
        tick(2);
        sync_now();
        tick(1);
        for (int k = 1; k <= 24; k++) begin
            tick(1);
            if (k >= 9 && k <= first) check("strobe after sync", 32'(k == first), 32'(ws));
        end
        check("strobe at clock 24", 32'h1, 32'(ws));
        check("second chip strobe at clock 24", 32'h1, 32'(ws_q));
    endtask
    task automatic test_latency(logic cm, logic [2:0] sel);
        int base, l;
        base = cm ? 35 : 41;
        l = (cm ? 20 : 40) << sel;
        complex_mode = cm;
        dec_sel = sel;
        sample_in = 12'h000;
        tick(2);
        sync_now();
        tick(30);
        sample_in = 12'h064;
        sample_q = 12'h032;
        tick(base + l / 2);
        check("before midpoint", 32'(100 * (l / 2 - 1)), 32'(data_out));
        tick(1);
        check("midpoint", 32'(50 * l), 32'(data_out));
        tick(l / 2 - 1);
        check("before endpoint", 32'(100 * (l - 1)), 32'(data_out));
        tick(1);
        check("endpoint", 32'(100 * l), 32'(data_out));
        tick(3);
        check("settled", 32'(100 * l), 32'(data_out));
        check("pair sum", 32'(150 * l), 32'(iq_sum));
        check("pair difference", 32'(50 * l), 32'(iq_dif));
        sample_in = 12'h000;
        sample_q = 12'h000;
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst_n, complex_mode, one_shot_req, fire, dec_sel} = '0;
        {freq_word, sample_in, sample_q, n_errors, cmp_count} = '0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        test_accum();
        for (int s = 0; s < 6; s++) test_sync(1'b0, 3'(s), s < 4 ? 8 + (1 << s) : 24);
        test_sync(1'b1, 3'h1, 10);
        test_sync(1'b1, 3'h6, 24);
        test_sync(1'b0, 3'h7, 24);
        test_sync(1'b1, 3'h0, 10);
        test_latency(1'b0, 3'h0);
        test_latency(1'b0, 3'h5);
        test_latency(1'b1, 3'h1);
        test_latency(1'b1, 3'h6);
        report_and_stop();
    end
    // Whole run is about 3200 clocks
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
endmodule // tsl_top_tb_top
